// file: src/output_clock_divider_crosspoint.sv
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
module output_clock_divider_crosspoint #(
  parameter int HSDIVS = clkpath_pkg::NUM_HS,
  parameter int OUTS = clkpath_pkg::NUM_OUT
) (
  // clock and reset; clk is the VCO clock
  input wire logic clk,
  input wire logic rstn,
  // register bus
  input wire clkpath_pkg::ahb_req_t bus_req,
  output clkpath_pkg::ahb_rsp_t bus_rsp,
  // reference and input buffer clocks, ordered as first-select codes
  input wire logic [clkpath_pkg::NUM_PASS-1:0] pass_clk_in,
  // output clocks, one pulse per output period
  output logic [clkpath_pkg::NUM_OUT-1:0] out_clk
);
  import clkpath_pkg::*;

  // select codes and the group map are fixed, so other counts are refused at elaboration
  if (HSDIVS != NUM_HS || OUTS != NUM_OUT)
  begin : g_bad_params
    $error("select codes and group map fix five dividers and twelve outputs");
  end

  logic [HS_W-1:0] hs_div_r [NUM_HS];
  frac_cfg_t frac_r [NUM_FRAC];
  frac_cfg_t fb_r;
  logic [1:0] gsel1_r [NUM_GRP];
  logic [2:0] gsel2_r [NUM_GRP];
  logic [FIN_W-1:0] fin_r [NUM_OUT];
  logic [NUM_HS+NUM_FRAC-1:0] src_tick;
  logic [NUM_PASS-1:0] pass_tick;
  logic [NUM_GRP-1:0] grp_tick;

  function automatic logic [7:0] word_of(input logic [7:0] base, input int idx);
    word_of = base + 8'(idx * 4);
  endfunction : word_of

  function automatic logic fault_of(input frac_cfg_t f);
    fault_of = (f.rem >= f.den) && (f.den != '0);
  endfunction : fault_of

  // bus: zero wait states, always OKAY
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic addr_ok;
  logic [31:0] rd_nxt;

  assign addr_ok = bus_req.hsel && bus_req.htrans[1] && bus_req.hready;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end
    else
    begin
      wr_pend_r <= addr_ok && bus_req.hwrite;
      if (addr_ok)
        wr_addr_r <= {bus_req.haddr[7:2], 2'b00};
    end
  end

  always_comb
  begin
    rd_nxt = '0;
    for (int i = 0; i < NUM_HS; i++)
      if ({bus_req.haddr[7:2], 2'b00} == word_of(OFS_HSDIV, i))
        rd_nxt = 32'(hs_div_r[i]);
    for (int i = 0; i < NUM_FRAC; i++)
    begin
      if ({bus_req.haddr[7:2], 2'b00} == 8'(OFS_FRAC + 8'(i) * FRAC_STRIDE + SUB_INT))
        rd_nxt = 32'(frac_r[i].integ);
      if ({bus_req.haddr[7:2], 2'b00} == 8'(OFS_FRAC + 8'(i) * FRAC_STRIDE + SUB_REM))
        rd_nxt = 32'(frac_r[i].rem);
      if ({bus_req.haddr[7:2], 2'b00} == 8'(OFS_FRAC + 8'(i) * FRAC_STRIDE + SUB_DEN))
        rd_nxt = 32'(frac_r[i].den);
    end
    if ({bus_req.haddr[7:2], 2'b00} == 8'(OFS_FB + SUB_INT))
      rd_nxt = 32'(fb_r.integ);
    if ({bus_req.haddr[7:2], 2'b00} == 8'(OFS_FB + SUB_REM))
      rd_nxt = 32'(fb_r.rem);
    if ({bus_req.haddr[7:2], 2'b00} == 8'(OFS_FB + SUB_DEN))
      rd_nxt = 32'(fb_r.den);
    for (int g = 0; g < NUM_GRP; g++)
      if ({bus_req.haddr[7:2], 2'b00} == word_of(OFS_GSEL, g))
      begin
        rd_nxt[GSEL1_LSB +: 2] = gsel1_r[g];
        rd_nxt[GSEL2_LSB +: 3] = gsel2_r[g];
      end
    for (int k = 0; k < NUM_OUT; k++)
      if ({bus_req.haddr[7:2], 2'b00} == word_of(OFS_FIN, k))
        rd_nxt = 32'(fin_r[k]);
    if ({bus_req.haddr[7:2], 2'b00} == OFS_STATUS)
    begin
      rd_nxt[NUM_OUT-1:0] = out_clk;
      for (int i = 0; i < NUM_FRAC; i++)
        rd_nxt[ST_FRAC_FAULT + i] = fault_of(frac_r[i]);
      rd_nxt[ST_FB_FAULT] = fault_of(fb_r);
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      bus_rsp <= '{hreadyout: 1'b0, hresp: 1'b0, hrdata: 32'h0};
    else
    begin
      bus_rsp.hreadyout <= 1'b1;
      bus_rsp.hresp <= 1'b0;
      if (addr_ok && !bus_req.hwrite)
        bus_rsp.hrdata <= rd_nxt;
    end
  end

  // configuration writes; fractional and feedback fields are 15 bits wide, integer dividers 8, final dividers 6, higher write bits dropped
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NUM_HS; i++)
        hs_div_r[i] <= HS_MIN;
      for (int i = 0; i < NUM_FRAC; i++)
        frac_r[i] <= '{integ: FRAC_INT_RST, rem: '0, den: DEN_RST};
      fb_r <= '{integ: '0, rem: '0, den: DEN_RST};
      for (int g = 0; g < NUM_GRP; g++)
      begin
        gsel1_r[g] <= '0;
        gsel2_r[g] <= '0;
      end
      for (int k = 0; k < NUM_OUT; k++)
        fin_r[k] <= '0;
    end
    else if (wr_pend_r)
    begin
      for (int i = 0; i < NUM_HS; i++)
        if (wr_addr_r == word_of(OFS_HSDIV, i))
          hs_div_r[i] <= bus_req.hwdata[HS_W-1:0];
      for (int i = 0; i < NUM_FRAC; i++)
      begin
        if (wr_addr_r == 8'(OFS_FRAC + 8'(i) * FRAC_STRIDE + SUB_INT))
          frac_r[i].integ <= bus_req.hwdata[FRAC_W-1:0];
        if (wr_addr_r == 8'(OFS_FRAC + 8'(i) * FRAC_STRIDE + SUB_REM))
          frac_r[i].rem <= bus_req.hwdata[FRAC_W-1:0];
        if (wr_addr_r == 8'(OFS_FRAC + 8'(i) * FRAC_STRIDE + SUB_DEN))
          frac_r[i].den <= bus_req.hwdata[FRAC_W-1:0];
      end
      // feedback ratio is held for the loop, which lives elsewhere
      if (wr_addr_r == 8'(OFS_FB + SUB_INT))
        fb_r.integ <= bus_req.hwdata[FRAC_W-1:0];
      if (wr_addr_r == 8'(OFS_FB + SUB_REM))
        fb_r.rem <= bus_req.hwdata[FRAC_W-1:0];
      if (wr_addr_r == 8'(OFS_FB + SUB_DEN))
        fb_r.den <= bus_req.hwdata[FRAC_W-1:0];
      for (int g = 0; g < NUM_GRP; g++)
        if (wr_addr_r == word_of(OFS_GSEL, g))
        begin
          gsel1_r[g] <= bus_req.hwdata[GSEL1_LSB +: 2];
          gsel2_r[g] <= bus_req.hwdata[GSEL2_LSB +: 3];
        end
      for (int k = 0; k < NUM_OUT; k++)
        if (wr_addr_r == word_of(OFS_FIN, k))
          fin_r[k] <= bus_req.hwdata[FIN_W-1:0];
    end
  end

  // integer dividers; ratios below the floor are raised to it
  for (genvar i = 0; i < NUM_HS; i++)
  begin : g_hs
    logic [HS_W-1:0] cnt_r;
    logic tick_r;
    logic [HS_W-1:0] ratio;
    assign ratio = (hs_div_r[i] < HS_MIN) ? HS_MIN : hs_div_r[i];
    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
      begin
        cnt_r <= '0;
        tick_r <= 1'b0;
      end
      else if (cnt_r == '0)
      begin
        cnt_r <= ratio - 8'h01;
        tick_r <= 1'b1;
      end
      else
      begin
        cnt_r <= cnt_r - 8'h01;
        tick_r <= 1'b0;
      end
    end
    assign src_tick[i] = tick_r;
  end

  // fractional stages: period in 1/128 steps, with a second remainder/denominator carry
  for (genvar i = 0; i < NUM_FRAC; i++)
  begin : g_frac
    logic [HS_W:0] cnt_r;
    logic [FRAC_SHIFT-1:0] acc_r;
    logic [FRAC_W-1:0] racc_r;
    logic tick_r;
    logic [HS_W-1:0] base;
    logic [FRAC_W:0] rsum;
    logic carry2;
    logic [FRAC_SHIFT:0] sum;
    logic [HS_W:0] period;
    assign base = (frac_r[i].integ[FRAC_W-1:FRAC_SHIFT] < FRAC_MIN) ? FRAC_MIN
                : frac_r[i].integ[FRAC_W-1:FRAC_SHIFT];
    assign rsum = {1'b0, racc_r} + {1'b0, frac_r[i].rem};
    // zero denominator means no fraction; remainder past it still wraps safely
    assign carry2 = (frac_r[i].den != '0) && (rsum >= {1'b0, frac_r[i].den});
    assign sum = {1'b0, acc_r} + {1'b0, frac_r[i].integ[FRAC_SHIFT-1:0]} + 8'(carry2);
    assign period = {1'b0, base} + 9'(sum[FRAC_SHIFT]);
    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
      begin
        cnt_r <= '0;
        acc_r <= '0;
        racc_r <= '0;
        tick_r <= 1'b0;
      end
      else if (cnt_r == '0)
      begin
        cnt_r <= period - 9'h001;
        acc_r <= sum[FRAC_SHIFT-1:0];
        racc_r <= carry2 ? FRAC_W'(rsum - {1'b0, frac_r[i].den}) : FRAC_W'(rsum);
        tick_r <= 1'b1;
      end
      else
      begin
        cnt_r <= cnt_r - 9'h001;
        tick_r <= 1'b0;
      end
    end
    assign src_tick[NUM_HS+i] = tick_r;
  end

  // pass-through inputs come from pins: synchronise, then take rising edges
  logic [NUM_PASS-1:0] pass_s1_r;
  logic [NUM_PASS-1:0] pass_s2_r;
  logic [NUM_PASS-1:0] pass_s3_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pass_s1_r <= '0;
      pass_s2_r <= '0;
      pass_s3_r <= '0;
    end
    else
    begin
      pass_s1_r <= pass_clk_in;
      pass_s2_r <= pass_s1_r;
      pass_s3_r <= pass_s2_r;
    end
  end
  // passed clocks must stay below a quarter of clk to be seen edge for edge
  assign pass_tick = pass_s2_r & ~pass_s3_r;

  // crosspoint: one source per group
  for (genvar g = 0; g < NUM_GRP; g++)
  begin : g_grp
    assign grp_tick[g] = (gsel2_r[g] == SEL2_PASS) ? pass_tick[gsel1_r[g]]
                       : src_tick[gsel2_r[g]];
  end

  // final dividers count group ticks; each output emits one pulse per period
  for (genvar k = 0; k < NUM_OUT; k++)
  begin : g_out
    logic [FIN_W-1:0] cnt_r;
    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
      begin
        cnt_r <= '0;
        out_clk[k] <= 1'b0;
      end
      else if (fin_r[k] == '0)
      begin
        cnt_r <= '0;
        out_clk[k] <= 1'b0;
      end
      else if (grp_tick[OUT_GROUP[k]])
      begin
        if (cnt_r >= fin_r[k] - 6'h01)
        begin
          cnt_r <= '0;
          out_clk[k] <= 1'b1;
        end
        else
        begin
          cnt_r <= cnt_r + 6'h01;
          out_clk[k] <= 1'b0;
        end
      end
      else
        out_clk[k] <= 1'b0;
    end
  end

endmodule : output_clock_divider_crosspoint

// file: src/clkpath_pkg.sv
package clkpath_pkg;

  localparam int NUM_HS = 5;
  localparam int NUM_FRAC = 2;
  localparam int NUM_GRP = 6;
  localparam int NUM_OUT = 12;
  localparam int NUM_PASS = 4;
  localparam int HS_W = 8;
  localparam int FRAC_W = 15;
  localparam int FRAC_SHIFT = 7;
  localparam int FIN_W = 6;

  localparam logic [HS_W-1:0] HS_MIN = 8'h08;
  localparam logic [HS_W-1:0] HS_MAX = 8'hff;
  localparam logic [HS_W-1:0] FRAC_MIN = 8'h0a;
  localparam logic [HS_W-1:0] FRAC_MAX = 8'hff;

  // second-stage select codes
  localparam logic [2:0] SEL2_FRAC0 = 3'h5;
  localparam logic [2:0] SEL2_PASS = 3'h7;

  // byte offsets on the register bus
  localparam logic [7:0] OFS_HSDIV = 8'h00;
  localparam logic [7:0] OFS_FRAC = 8'h20;
  localparam logic [7:0] FRAC_STRIDE = 8'h10;
  localparam logic [7:0] OFS_FB = 8'h40;
  localparam logic [7:0] OFS_GSEL = 8'h50;
  localparam logic [7:0] OFS_FIN = 8'h80;
  localparam logic [7:0] OFS_STATUS = 8'hc0;
  localparam logic [7:0] SUB_INT = 8'h00;
  localparam logic [7:0] SUB_REM = 8'h04;
  localparam logic [7:0] SUB_DEN = 8'h08;

  // group select layout
  localparam int GSEL1_LSB = 0;
  localparam int GSEL2_LSB = 4;

  // status layout
  localparam int ST_FRAC_FAULT = 12;
  localparam int ST_FB_FAULT = 14;

  // reset values
  localparam logic [FRAC_W-1:0] FRAC_INT_RST = 15'h0500;
  localparam logic [FRAC_W-1:0] DEN_RST = 15'h0001;

  // group each output belongs to
  localparam logic [2:0] OUT_GROUP [NUM_OUT] = '{3'h0, 3'h1, 3'h1, 3'h2, 3'h2, 3'h2,
                                                 3'h3, 3'h3, 3'h3, 3'h4, 3'h5, 3'h5};

  typedef struct packed {
    logic [FRAC_W-1:0] integ;
    logic [FRAC_W-1:0] rem;
    logic [FRAC_W-1:0] den;
  } frac_cfg_t;

  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } ahb_rsp_t;

endpackage : clkpath_pkg

// file: tb/output_clock_divider_crosspoint_props.sv
`timescale 1ns/1ps
module output_clock_divider_crosspoint_props #(
  parameter int HSDIVS = clkpath_pkg::NUM_HS,
  parameter int OUTS = clkpath_pkg::NUM_OUT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register bus
  input wire clkpath_pkg::ahb_req_t bus_req,
  input wire clkpath_pkg::ahb_rsp_t bus_rsp,
  // clocks
  input wire logic [clkpath_pkg::NUM_PASS-1:0] pass_clk_in,
  input wire logic [clkpath_pkg::NUM_OUT-1:0] out_clk
);
  import clkpath_pkg::*;
  logic rd_take;
  logic fin_wr_r;
  logic [5:0] fin0_r;
  logic [1:0] idle_cnt_r;
  assign rd_take = bus_req.hsel && bus_req.htrans[1] && bus_req.hready && !bus_req.hwrite;
  // shadow of final divider 0, loaded in the write data phase like the register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      fin_wr_r <= 1'b0;
      fin0_r <= 6'h00;
    end
    else
    begin
      fin_wr_r <= bus_req.hsel && bus_req.htrans[1] && bus_req.hready && bus_req.hwrite &&
                  bus_req.haddr[7:0] == OFS_FIN;
      if (fin_wr_r)
        fin0_r <= bus_req.hwdata[5:0];
    end
  end
  // a pulse may still be in flight when the output is turned off, so allow a short settle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      idle_cnt_r <= 2'h0;
    else
      idle_cnt_r <= (fin0_r != 6'h00) ? 2'h0 : ((idle_cnt_r == 2'h3) ? 2'h3 : idle_cnt_r + 2'h1);
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  AST_PULSE_ONE: assert property (|out_clk |=> (out_clk & $past(out_clk)) == '0)
    else $error("output clock pulse longer than one cycle");
  AST_PULSE_GAP: assert property ($rose(out_clk[0]) |=> !out_clk[0] [*3])
    else $error("output 0 pulses closer than four cycles");
  AST_INT_WIDTH: assert property (rd_take && bus_req.haddr[7:5] == 3'h0
    |=> bus_rsp.hrdata[31:8] == '0)
    else $error("integer divider reads wider than 8 bits");
  AST_FRAC_WIDTH: assert property (rd_take && bus_req.haddr[7:5] == 3'h1
    |=> bus_rsp.hrdata[31:15] == '0)
    else $error("fractional field reads wider than 15 bits");
  AST_FB_WIDTH: assert property (rd_take && bus_req.haddr[7:4] == 4'h4
    |=> bus_rsp.hrdata[31:15] == '0)
    else $error("feedback field reads wider than 15 bits");
  AST_GSEL_FIELDS: assert property (rd_take && bus_req.haddr[7:6] == 2'h1 && bus_req.haddr[5:4] != 2'h0
    |=> (bus_rsp.hrdata & 32'hffffff8c) == '0)
    else $error("group select reads bits outside its fields");
  AST_FIN_WIDTH: assert property (rd_take && bus_req.haddr[7:6] == 2'h2
    |=> bus_rsp.hrdata[31:6] == '0)
    else $error("final divider reads wider than 6 bits");
  AST_FIN_OFF: assert property (idle_cnt_r == 2'h3 |-> !out_clk[0])
    else $error("output 0 pulses while its final divider is 0");
endmodule : output_clock_divider_crosspoint_props

bind output_clock_divider_crosspoint output_clock_divider_crosspoint_props #(.HSDIVS(HSDIVS), .OUTS(OUTS)) u_props (
  .clk(clk), .rstn(rstn), .bus_req(bus_req), .bus_rsp(bus_rsp), .pass_clk_in(pass_clk_in), .out_clk(out_clk));

// file: tb/test_output_clock_divider_crosspoint.sv
`timescale 1ns/1ps
module test_output_clock_divider_crosspoint;
  import clkpath_pkg::*;
  logic clk;
  logic rstn;
  logic m_sel;
  logic [31:0] m_addr;
  logic [1:0] m_trans;
  logic m_write;
  logic [2:0] m_size;
  logic [31:0] m_wdata;
  ahb_req_t req;
  ahb_rsp_t rsp;
  logic [NUM_PASS-1:0] pass_clk_in;
  logic [NUM_OUT-1:0] out_clk;
  logic [31:0] rd;
  int num_errors;
  int checks;
  int cyc;
  int sum;
  int p;
  int hv [5] = '{8, 9, 100, 254, 255};
  // single slave, so its hreadyout is the bus hready
  assign req = {m_sel, m_addr, m_trans, m_write, m_size, rsp.hreadyout, m_wdata};
  output_clock_divider_crosspoint dut (.clk(clk), .rstn(rstn), .bus_req(req), .bus_rsp(rsp),
    .pass_clk_in(pass_clk_in), .out_clk(out_clk));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // pass clocks with half periods of 4 to 7 cycles, kept below clk/4 for the synchroniser
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    for (int i = 0; i < NUM_PASS; i++)
      pass_clk_in[i] <= (cyc % (8 + 2 * i)) < (4 + i);
    if (cyc == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end
  task print_verdict;
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    m_sel <= 1'b1;
    m_addr <= {24'h000000, a};
    m_trans <= 2'h2;
    m_write <= w;
    m_size <= 3'h2;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    m_trans <= 2'h0;
    m_wdata <= d;
    do @(posedge clk); while (rsp.hreadyout !== 1'b1);
    r = rsp.hrdata;
    check(32'(rsp.hresp), 32'h0);
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask : wr
  // skips two pulses so a new setting has reloaded, then counts one full period
  task per(input int k, output int n);
    n = 0;
    repeat (2)
    begin
      @(negedge clk);
      while (out_clk[k] !== 1'b1) @(negedge clk);
    end
    do
    begin
      @(negedge clk);
      n++;
    end while (out_clk[k] !== 1'b1);
  endtask : per
  initial
  begin
    rstn = 1'b0;
    m_sel = 1'b0;
    m_addr = 32'h0;
    m_trans = 2'h0;
    m_write = 1'b0;
    m_size = 3'h2;
    m_wdata = 32'h0;
    pass_clk_in = '0;
    cyc = 0;
    num_errors = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    bus(OFS_HSDIV, 1'b0, 32'h0, rd);
    check(rd, 32'h8);
    bus(OFS_FRAC, 1'b0, 32'h0, rd);
    check(rd, 32'h0500);
    bus(OFS_FRAC + SUB_DEN, 1'b0, 32'h0, rd);
    check(rd, 32'h1);
    bus(OFS_FB, 1'b0, 32'h0, rd);
    check(rd, 32'h0);
    bus(OFS_GSEL + 8'h04, 1'b0, 32'h0, rd);
    check(rd, 32'h0);
    bus(OFS_FIN, 1'b0, 32'h0, rd);
    check(rd, 32'h0);
    bus(8'hfc, 1'b0, 32'h0, rd);
    check(rd, 32'h0);
    wr(OFS_FIN, 32'h1);
    for (int c = 0; c < NUM_HS; c++)
    begin
      wr(OFS_HSDIV + 8'(4 * c), hv[c]);
      wr(OFS_GSEL, 32'(c) << GSEL2_LSB);
      per(0, p);
      check(p, hv[c]);
    end
    // group 1 shares integer divider 0 (ratio 8) between two final ratios
    wr(OFS_FIN + 8'h04, 32'd63);
    wr(OFS_FIN + 8'h08, 32'd5);
    per(1, p);
    check(p, 8 * 63);
    per(2, p);
    check(p, 8 * 5);
    wr(OFS_GSEL, 32'(SEL2_FRAC0) << GSEL2_LSB);
    per(0, p);
    check(p, 10);
    wr(OFS_FRAC + FRAC_STRIDE, 32'h7f80);
    wr(OFS_GSEL, 32'h60);
    per(0, p);
    check(p, 255);
    // ratio 10.5: periods alternate, and the two measured ones are an odd count apart
    wr(OFS_FRAC, 32'h0540);
    wr(OFS_GSEL, 32'h50);
    per(0, sum);
    per(0, p);
    check(sum + p, 21);
    for (int s = 0; s < NUM_PASS; s++)
    begin
      wr(OFS_GSEL, 32'h70 | 32'(s));
      per(0, p);
      check(p, 8 + 2 * s);
    end
    // a feedback ratio of 100 puts a 25 MHz reference at the middle of the vco range
    wr(OFS_FB, 32'h00003200);
    bus(OFS_FB, 1'b0, 32'h0, rd);
    check(rd, 32'h00003200);
    // upper write bits are dropped, fields keep 15 bits
    wr(OFS_FB + SUB_DEN, 32'hffffffff);
    bus(OFS_FB + SUB_DEN, 1'b0, 32'h0, rd);
    check(rd, 32'h00007fff);
    wr(OFS_FRAC + SUB_REM, 32'h1);
    wr(OFS_FRAC + SUB_DEN, 32'h2);
    bus(OFS_FRAC + SUB_REM, 1'b0, 32'h0, rd);
    check(rd, 32'h1);
    bus(OFS_STATUS, 1'b0, 32'h0, rd);
    check(rd & 32'hfffff000, 32'h0);
    // feedback remainder equal to its denominator breaks the rule and must be flagged
    wr(OFS_FB + SUB_REM, 32'h00007fff);
    bus(OFS_STATUS, 1'b0, 32'h0, rd);
    check(rd & 32'hfffff000, 32'h1 << ST_FB_FAULT);
    wr(OFS_FIN, 32'h0);
    repeat (4) @(negedge clk);
    sum = 0;
    repeat (300)
    begin
      @(negedge clk);
      if (out_clk[0] === 1'b1)
        sum++;
    end
    check(sum, 0);
    print_verdict();
  end
endmodule : test_output_clock_divider_crosspoint
